/* File: include/modem_baud_pkg.sv */
// ==========================================
// Register map and field layout
package modem_baud_pkg;
  // Byte offsets of the AXI4-Lite word registers
  localparam logic [4:0] OFF_LINE_CTRL = 5'h00; // Bit 7 divisor access select
  localparam logic [4:0] OFF_MODEM_CTRL = 5'h04; // Modem output control
  localparam logic [4:0] OFF_STATUS = 5'h08; // Modem line status
  localparam logic [4:0] OFF_DIV_A = 5'h0c; // Divisor low byte, window 1
  localparam logic [4:0] OFF_DIV_B = 5'h10; // Divisor high byte, window 1
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h14; // Sticky events, write one to clear
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18; // Event mask
  localparam logic [4:0] OFF_FLOW = 5'h1c; // Flow configuration, read only
  // Field positions
  localparam int DIV_ACCESS_POS = 7;
  localparam int LOOPBACK_POS = 4;
  localparam int AUTO_FLOW_POS = 5;
  localparam int RTS_POS = 1;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Modem handshake inputs, pin level
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_type;

  // Modem handshake outputs, pin level
  typedef struct packed {
    logic user_output_two_n;
    logic user_output_one_n;
    logic rts_n;
    logic dtr_n;
  } modem_out_type;
endpackage

/* File: testbench/modem_partner.sv */
`timescale 1ns/1ps
// ==========================
// Data set model driving the handshake pins
module modem_partner (
  input wire logic aclk,
  input wire logic [3:0] level_n,
  output modem_baud_pkg::modem_in_type pins_n
);
  import modem_baud_pkg::*;
  // Pins move just after an edge, never glitching
  always_ff @(posedge aclk) begin
    pins_n <= level_n;
  end
endmodule

/* File: testbench/modem_status_baud_sva.sv */
`timescale 1ns/1ps
// ==========================
// Port checker
module modem_status_baud_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic baud_tick,
  input wire logic auto_rts_en,
  input wire logic auto_cts_en,
  input wire logic irq,
  input wire modem_baud_pkg::modem_out_type modem_out_n
);
  import modem_baud_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken together
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response one idle cycle later
  sequence late_resp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  flow_pair_a: assert property (auto_rts_en |-> auto_cts_en)
    else $error("auto rts without auto cts");
  reset_quiet_a: assert property ($rose(aresetn) |-> !auto_cts_en && !irq
    && !baud_tick && modem_out_n == 4'hf) else $error("outputs busy after reset");
  write_answer_a: assert property (both_taken |=> late_resp)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule
bind modem_status_baud modem_status_baud_chk modem_status_baud_chk_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .baud_tick, .auto_rts_en, .auto_cts_en, .irq, .modem_out_n);

/* File: testbench/test_modem_status_baud.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_modem_status_baud;
  import modem_baud_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, baud_tick, auto_rts_en, auto_cts_en, irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [3:0] level_n;
  modem_in_type modem_in_n;
  modem_out_type modem_out_n;
  int n_fail, checks, cyc;
  modem_status_baud modem_status_baud_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modem_in_n, .modem_out_n, .baud_tick, .auto_rts_en, .auto_cts_en, .irq);
  modem_partner modem_partner_inst (.aclk, .level_n, .pins_n(modem_in_n));
  // ==========================
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================
  // Bus master
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ==========================
  // Scenarios
  task automatic t_flow();
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'h00;
      m[AUTO_FLOW_POS] = i[1];
      m[RTS_POS] = i[0];
      wr(OFF_MODEM_CTRL, m);
      repeat (2) @(posedge aclk);
      `CHK("auto rts", i[1] & i[0], auto_rts_en)
      `CHK("auto cts", i[1], auto_cts_en)
      rd(OFF_FLOW);
      `CHK("flow reg", {30'h0, i[1], i[1] & i[0]}, rd_v)
    end
    $display("flow test done");
  endtask
  task automatic t_status();
    wr(OFF_MODEM_CTRL, 8'h00);
    rd(OFF_STATUS);
    wr(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_IRQ_MASK, 8'h01);
    level_n <= 4'h0;
    repeat (8) @(posedge aclk);
    rd(OFF_STATUS);
    `CHK("status pins low", 32'hfb, rd_v)
    rd(OFF_STATUS);
    `CHK("status cleared", 32'hf0, rd_v)
    `CHK("irq raised", 1'b1, irq)
    wr(OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    level_n <= 4'hf;
    repeat (8) @(posedge aclk);
    rd(OFF_STATUS);
    `CHK("status pins high", 32'h0f, rd_v)
    wr(OFF_MODEM_CTRL, 8'h20);
    level_n <= 4'he;
    repeat (8) @(posedge aclk);
    rd(OFF_STATUS);
    `CHK("cts change hidden", 32'h10, rd_v)
    $display("status test done");
  endtask
  task automatic t_loop();
    wr(OFF_MODEM_CTRL, 8'h05);
    repeat (2) @(posedge aclk);
    `CHK("pins driven", 4'ha, modem_out_n)
    wr(OFF_MODEM_CTRL, 8'h1b);
    level_n <= 4'h0;
    repeat (8) @(posedge aclk);
    `CHK("pins idle", 4'hf, modem_out_n)
    rd(OFF_STATUS);
    `CHK("loop status", 8'hb0, rd_v[7:0] & 8'hf0)
    wr(OFF_MODEM_CTRL, 8'h00);
    $display("loop test done");
  endtask
  task automatic t_baud();
    logic [15:0] dv [4] = '{16'd3, 16'd12, 16'd5, 16'd20};
    int n;
    wr(OFF_LINE_CTRL, 8'h80);
    `CHK("write okay", RESP_OKAY, wr_r)
    for (int i = 0; i < 4; i++) begin
      wr(OFF_DIV_B, dv[i][15:8]);
      wr(OFF_DIV_A, dv[i][7:0]);
      do @(posedge aclk); while (!baud_tick);
      n = 0;
      do begin @(posedge aclk); n++; end while (!baud_tick);
      `CHK("tick period", dv[i], 16'(n))
    end
    rd(OFF_DIV_A);
    `CHK("latch a", 32'h14, rd_v)
    wr(OFF_LINE_CTRL, 8'h00);
    rd(OFF_DIV_A);
    `CHK("latch hidden", 32'h0, rd_v)
    rd(5'h13);
    `CHK("bad address", RESP_SLVERR, rd_r)
    wr(5'h13, 8'h00);
    `CHK("bad write", RESP_SLVERR, wr_r)
    $display("baud test done");
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    level_n = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_flow();
    t_status();
    t_loop();
    t_baud();
    complete_run();
  end
endmodule

/* File: verilog/modem_status_baud.sv */
`timescale 1ns/1ps
// Behaviour
// - Autoflow with RTS bit: auto RTS and CTS
// - Autoflow off disables both automatic modes
// - Four change bits, cleared by status read
// - Bit 0 CTS change, suppressed under autoflow
// - Bit 1 DSR change raises modem interrupt
// - Bit 2 RI low-to-high edge detected
// - Bit 3 DCD change raises modem interrupt
// - Bits 4-7 complement CTS DSR RI DCD
// - Loopback: bits 4-7 from control bits
// - Divide clock by divisor, 16x output
// - Divisor is two 8-bit latches
// - Latch write reloads the baud counter
// - 1.8432 MHz: 12 gives 9600, 3 38400
// - 3.072 MHz: 20 gives 9600, 5 38400
// - Divisor access select gates latch access
// - Loopback isolates inputs, outputs driven high
// - Control bit set drives output low
module modem_status_baud (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modem side
  input wire modem_baud_pkg::modem_in_type modem_in_n,
  output modem_baud_pkg::modem_out_type modem_out_n,
  output logic baud_tick,
  output logic auto_rts_en,
  output logic auto_cts_en,
  output logic irq
);
  import modem_baud_pkg::*;

  // ==========================================
  // Overview
  // One state struct, one next-state process, one register.
  // Modem pins pass two flops before any compare.
  // The bus answers one write and one read at a time.
  // Divisor zero leaves the baud counter stopped.

  // ==========================================
  // State
  typedef struct packed {
    // Bus channel state
    logic [4:0] awaddr; // Captured write address
    logic aw_held; // Write address taken
    logic [31:0] wdata; // Captured write data
    logic [3:0] wstrb; // Captured strobes
    logic w_held; // Write data taken
    logic bvalid; // Write response pending
    logic [1:0] bresp; // Write response code
    logic rvalid; // Read data pending
    logic [31:0] rdata; // Read data
    logic [1:0] rresp; // Read response code
    // Software registers
    logic [7:0] line_ctrl; // Line control byte
    logic [7:0] modem_output_control; // Modem control byte
    logic [7:0] div_a; // Divisor low latch
    logic [7:0] div_b; // Divisor high latch
    // Baud generator
    logic [15:0] baud_count; // Baud down counter
    logic baud_tick; // 16x enable pulse
    // Modem input path
    logic [3:0] sync1; // First synchroniser stage
    logic [3:0] sync2; // Second synchroniser stage
    logic [3:0] eff_prev; // Previous effective inputs
    logic [3:0] changed; // Change indicators, bits 0 to 3
    // Interrupts
    logic [1:0] irq_status; // 0 modem event, 1 baud tick
    logic [1:0] irq_mask; // Enable per event
    logic irq; // Interrupt output
    // Modem and flow outputs
    modem_out_type mout; // Modem pins
    logic auto_rts; // Auto RTS enable
    logic auto_cts; // Auto CTS enable
  } state_type;

  // Registered state and its next value
  state_type state_reg, state_next;

  // ==========================================
  // Next state
  // Bus capture, register writes and reads, change detection,
  // baud counting and interrupt flags all settle here.
  // Later assignments override earlier ones on purpose.
  always_comb begin
    // Per-cycle helpers, all set at the top
    logic aw_take; // Address accepted this cycle
    logic w_take; // Data accepted this cycle
    logic do_write; // Both halves present
    logic ar_take; // Read accepted this cycle
    logic div_sel; // Divisor window open
    logic status_read; // Status register being read
    logic loop_on; // Loopback mode
    logic [3:0] eff; // Effective active-high inputs: cts dsr ri dcd
    logic [3:0] events; // Change events this cycle
    logic [7:0] status_view; // Status byte as read
    logic [31:0] rd; // Read mux
    logic hit; // Mapped address
    // Defaults
    aw_take = 1'b0;
    w_take = 1'b0;
    do_write = 1'b0;
    ar_take = 1'b0;
    div_sel = 1'b0;
    status_read = 1'b0;
    loop_on = 1'b0;
    eff = 4'h0;
    events = 4'h0;
    status_view = 8'h00;
    rd = 32'h0000_0000;
    hit = 1'b0;
    state_next = state_reg;

    // Window select and loopback mode from the control bytes
    div_sel = state_reg.line_ctrl[DIV_ACCESS_POS];
    loop_on = state_reg.modem_output_control[LOOPBACK_POS];

    // Synchronise the modem pins
    // Stage one feeds only stage two; metastability settles there
    state_next.sync1 = modem_in_n;
    state_next.sync2 = state_reg.sync1;

    // Effective inputs, active high
    if (loop_on) begin
      // Control bits replace the pins
      eff[0] = state_reg.modem_output_control[1];
      eff[1] = state_reg.modem_output_control[0];
      eff[2] = state_reg.modem_output_control[2];
      eff[3] = state_reg.modem_output_control[3];
    end else begin
      // Complement of the pin levels
      eff = ~state_reg.sync2;
    end
    // Remember this view for the next compare
    state_next.eff_prev = eff;

    // Compare against last cycle's view, so a pin edge and a
    // loopback toggle both register as one event.
    // Entering or leaving loopback can itself flag changes.
    // Change detection
    events[0] = (eff[0] != state_reg.eff_prev[0]) && !state_reg.auto_cts;
    events[1] = eff[1] != state_reg.eff_prev[1];
    // Ring ends: active ring drops, pin returns high
    events[2] = !eff[2] && state_reg.eff_prev[2];
    events[3] = eff[3] != state_reg.eff_prev[3];

    // Status byte: levels in the high nibble, change flags low
    status_view = {eff[3], eff[2], eff[1], eff[0], state_reg.changed};

    // Address and data may arrive in either order; each is
    // held until the response handshake completes
    // Write channel capture
    if (!state_reg.aw_held && s_axi_awvalid) begin
      aw_take = 1'b1;
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (!state_reg.w_held && s_axi_wvalid) begin
      w_take = 1'b1;
      state_next.w_held = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    // Write proceeds once both halves are held and no answer waits
    do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;

    // Terminal count at one, so the period equals the divisor
    // Divisor zero holds the counter still and no tick is made
    // Baud counter, counts down and reloads
    state_next.baud_tick = 1'b0;
    if ({state_reg.div_b, state_reg.div_a} != 16'h0000) begin
      if (state_reg.baud_count <= 16'h0001) begin
        state_next.baud_tick = 1'b1;
        state_next.baud_count = {state_reg.div_b, state_reg.div_a};
      end else begin
        state_next.baud_count = state_reg.baud_count - 16'h0001;
      end
    end

    // Register writes
    // Both halves held: apply the write, answer next cycle
    if (do_write) begin
      // Halves stay held until the response is taken
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      unique case (state_reg.awaddr)
        // Line control, bit 7 opens the divisor window
        OFF_LINE_CTRL: begin
          if (state_reg.wstrb[0]) state_next.line_ctrl = state_reg.wdata[7:0];
        end
        // Modem control: outputs, loopback, autoflow
        OFF_MODEM_CTRL: begin
          if (state_reg.wstrb[0]) state_next.modem_output_control = state_reg.wdata[7:0];
        end
        // Low divisor byte, reloads the counter
        OFF_DIV_A: begin
          if (div_sel && state_reg.wstrb[0]) begin
            state_next.div_a = state_reg.wdata[7:0];
            state_next.baud_count = {state_reg.div_b, state_reg.wdata[7:0]};
          end
        end
        // High divisor byte, reloads the counter
        OFF_DIV_B: begin
          if (div_sel && state_reg.wstrb[0]) begin
            state_next.div_b = state_reg.wdata[7:0];
            state_next.baud_count = {state_reg.wdata[7:0], state_reg.div_a};
          end
        end
        OFF_IRQ_STATUS: begin
          // Write one to clear; a new event below still wins
          if (state_reg.wstrb[0])
            state_next.irq_status = state_reg.irq_status & ~state_reg.wdata[1:0];
        end
        // Event mask
        OFF_IRQ_MASK: begin
          if (state_reg.wstrb[0]) state_next.irq_mask = state_reg.wdata[1:0];
        end
        OFF_STATUS, OFF_FLOW: begin
          // Read only, write ignored
        end
        // Unmapped offset
        default: begin
          state_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Response taken: free both channels for the next write
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
    end

    // One read at a time; data and code are registered and stand
    // until the read response handshake
    // Register reads
    if (!state_reg.rvalid && s_axi_arvalid) begin
      ar_take = 1'b1;
      hit = 1'b1;
      unique case (s_axi_araddr)
        OFF_LINE_CTRL: rd = {24'h0, state_reg.line_ctrl};
        OFF_MODEM_CTRL: rd = {24'h0, state_reg.modem_output_control};
        OFF_STATUS: begin
          rd = {24'h0, status_view};
          // Change flags clear below, at this taken edge
          status_read = 1'b1;
        end
        OFF_DIV_A: rd = div_sel ? {24'h0, state_reg.div_a} : 32'h0;
        OFF_DIV_B: rd = div_sel ? {24'h0, state_reg.div_b} : 32'h0;
        OFF_IRQ_STATUS: rd = {30'h0, state_reg.irq_status};
        OFF_IRQ_MASK: rd = {30'h0, state_reg.irq_mask};
        OFF_FLOW: rd = {30'h0, state_reg.auto_cts, state_reg.auto_rts};
        // Unmapped offset reads zero
        default: hit = 1'b0;
      endcase
      // Answer on the next edge
      state_next.rvalid = 1'b1;
      state_next.rdata = rd;
      state_next.rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // Change indicators: read clears, coincident event survives
    // Clear and set in one cycle: set wins
    state_next.changed = (status_read ? 4'h0 : state_reg.changed) | events;

    // Sticky interrupt events, set after any clear
    // A write-one clear earlier in this process is overridden by
    // a new event, so no event is lost
    state_next.irq_status[0] = state_next.irq_status[0] | (|events);
    state_next.irq_status[1] = state_next.irq_status[1] | state_reg.baud_tick;
    state_next.irq = |(state_next.irq_status & state_reg.irq_mask);

    // Flow configuration
    // Autoflow alone gives auto CTS; with the RTS bit, auto RTS too
    // Registered, so it follows a control write by one cycle
    state_next.auto_cts = state_reg.modem_output_control[AUTO_FLOW_POS];
    state_next.auto_rts = state_reg.modem_output_control[AUTO_FLOW_POS]
                        & state_reg.modem_output_control[RTS_POS];

    // Modem outputs: set bit drives low, loopback forces high
    // In loopback the pins rest inactive while the status sees the bits
    if (loop_on) begin
      state_next.mout = 4'hf;
    end else begin
      state_next.mout = ~state_reg.modem_output_control[3:0];
    end
  end

  // ==========================================
  // State register
  // Synchronous reset to constants only
  // Synchroniser stages reset to the idle pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Clear everything, then set named reset values
      state_reg <= '0;
      state_reg.line_ctrl <= CTRL_RESET;
      state_reg.modem_output_control <= CTRL_RESET;
      state_reg.div_a <= DIV_RESET;
      state_reg.div_b <= DIV_RESET;
      state_reg.irq_status <= IRQ_RESET;
      state_reg.irq_mask <= IRQ_RESET;
      state_reg.sync1 <= 4'hf;
      state_reg.sync2 <= 4'hf;
      state_reg.mout <= 4'hf;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs
  // Write readies are inverted held flags, read ready is inverted rvalid; the rest are flops
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready = !state_reg.w_held;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign modem_out_n = state_reg.mout;
  assign baud_tick = state_reg.baud_tick;
  assign auto_rts_en = state_reg.auto_rts;
  assign auto_cts_en = state_reg.auto_cts;
  assign irq = state_reg.irq;
endmodule
